//--- core/acr_top.sv
/*
  acr_top: converter control and result access. Register port, power
  gating, reference and channel routing, gain, justification and the
  protected two-byte result read.
  assumes: comparator and analog mux outside; cmp_level is asynchronous.
*/
// Overview of operation
// - power-off bit holds converter inoperative
// - result is a 10-bit unsigned code
// - reference select picks pin, supply, internal sources
// - channel field split across two registers
// - sixteen single-ended inputs measured against ground
// - four pairs offer 1x, 10x, 200x gain
// - each of the two groups shares one negative terminal of its own
// - differential uses amplifier, single-ended bypasses it
// - selections take effect only once enabled
// - result placed right or left justified
// - low read blocks result updates
// - high read lifts the block
// - start bit reads one while converting
// - completion writes result and sets done
// - done flag sets even when result discarded
// - thirteen cycles, first after enable twenty-five
`timescale 1ns/1ns
module acr_top
  import acr_pkg::*;
(
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // analog front end
  input  wire logic              cmp_level,
  output logic      [RES_W-1:0]  dac_code,
  output logic                   analog_on,
  output logic      [1:0]        ref_sel,
  output logic                   ref_to_pin,
  output logic      [4:0]        pos_input,
  output logic                   neg_is_gnd,
  output logic      [3:0]        neg_input,
  output logic                   amp_bypass,
  output logic      [1:0]        amp_gain,
  output logic                   sel_bandgap
);

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [DATA_W-1:0] csra_q;       // enable, start, done
  logic [DATA_W-1:0] csrb_q;       // channel bit 5
  logic [DATA_W-1:0] mux_q;        // reference, adjust, channel
  logic [DATA_W-1:0] pwr_q;        // power-off bit
  logic [RES_W-1:0]  res_q;        // stored result code
  logic              ladj_q;       // copy of left-adjust bit, one cycle late
  logic              block_q;      // result writes blocked
  logic              first_q;      // next conversion is the first
  logic [5:0]        ch_act_q;     // channel used by converter
  logic [1:0]        ref_act_q;    // reference used by converter
  logic [DATA_W-1:0] rdata_q;      // read data
  logic [7:0]        div_q;        // converter clock divider
  logic [2:0]        cmp_sync_q;   // comparator synchroniser
  logic              cmp_q;        // filtered comparator level
  acr_state_t        state_q;

  logic              tick;
  logic              sar_busy;
  logic              sar_done;
  logic [RES_W-1:0]  sar_code;
  logic              powered;
  logic              conv_en;
  logic              sar_go;
  logic              wr_csra;

  assign powered = !pwr_q[PWR_OFF_BIT];
  assign conv_en = powered && csra_q[CSRA_EN_BIT];
  assign wr_csra = reg_wr && reg_addr == OFF_CSR_A;
  assign sar_go  = state_q == acr_wait_edge && tick;

  // --------------------------------------------------------------
  // justification helpers
  // --------------------------------------------------------------
  // byte placement
  function automatic logic [DATA_W-1:0] low_byte(input logic [RES_W-1:0] c, input logic l);
    low_byte = l ? {c[1:0], 6'h00} : c[7:0];
  endfunction

  function automatic logic [DATA_W-1:0] high_byte(input logic [RES_W-1:0] c, input logic l);
    high_byte = l ? c[9:2] : {6'h00, c[9:8]};
  endfunction

  // --------------------------------------------------------------
  // converter clock divider, held in reset while disabled
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || !conv_en) begin
      div_q <= '0;
    end else if (clk_en) begin
      div_q <= (div_q == 8'(CONV_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end
  assign tick = conv_en && div_q == 8'(CONV_DIV - 1);

  // comparator input: three stages, change taken when last two agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmp_sync_q <= '0;
      cmp_q      <= 1'b0;
    end else if (clk_en) begin
      cmp_sync_q <= {cmp_sync_q[1:0], cmp_level};
      if (cmp_sync_q[2] == cmp_sync_q[1]) begin
        cmp_q <= cmp_sync_q[2];
      end
    end
  end

  // --------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------
  // control writes; done flag is set by hardware, cleared by writing one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      csra_q <= RST_BYTE;
      csrb_q <= RST_BYTE;
      mux_q  <= RST_BYTE;
      pwr_q  <= PWR_RST;
    end else if (clk_en) begin
      if (wr_csra) begin
        csra_q[CSRA_EN_BIT] <= reg_wdata[CSRA_EN_BIT];
        csra_q[3:0]         <= reg_wdata[3:0];
        csra_q[5]           <= reg_wdata[5];
      end
      if (reg_wr && reg_addr == OFF_CSR_B) begin
        csrb_q <= reg_wdata & CSRB_WR_MASK;
      end
      if (reg_wr && reg_addr == OFF_MUX_SEL) begin
        mux_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == OFF_PWR_SAVE) begin
        pwr_q <= reg_wdata;
      end
      if (!conv_en) begin
        csra_q[CSRA_START_BIT] <= 1'b0;
      end else if (sar_done) begin
        csra_q[CSRA_START_BIT] <= 1'b0;
      end else if (wr_csra && reg_wdata[CSRA_START_BIT]) begin
        csra_q[CSRA_START_BIT] <= 1'b1;
      end
      // done sets even if discarded; set wins over clear
      if (sar_done) begin
        csra_q[CSRA_DONE_BIT] <= 1'b1;
      end else if (wr_csra && reg_wdata[CSRA_DONE_BIT]) begin
        csra_q[CSRA_DONE_BIT] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // conversion sequencing
  // --------------------------------------------------------------
  // start waits for next converter clock edge; selections frozen in a run
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q   <= acr_idle;
      first_q   <= 1'b1;
      ch_act_q  <= '0;
      ref_act_q <= REF_PIN;
    end else if (clk_en) begin
      if (!conv_en) begin
        state_q <= acr_idle;
        first_q <= 1'b1;
      end else begin
        // selections follow registers only outside a run
        if (state_q != acr_convert) begin
          ch_act_q  <= {csrb_q[CSRB_CH5_BIT], mux_q[MUX_CH_HI:0]};
          ref_act_q <= mux_q[MUX_REF_HI:MUX_REF_LO];
        end
        unique case (state_q)
          acr_idle: begin
            if (csra_q[CSRA_START_BIT]) begin
              state_q <= acr_wait_edge;
            end
          end
          acr_wait_edge: begin
            if (tick) begin
              // channel fixed per run from here on
              state_q <= acr_convert;
            end
          end
          acr_convert: begin
            if (sar_done) begin
              first_q <= 1'b0;
              state_q <= acr_idle;
            end
          end
        endcase
      end
    end
  end

  acr_sar u_sar (
    .core_clk (core_clk),
    .reset    (reset || !conv_en),
    .clk_en   (clk_en),
    .tick     (tick),
    .go       (sar_go),
    .first    (first_q),
    .cmp_high (cmp_q),
    .trial    (dac_code),
    .busy     (sar_busy),
    .done     (sar_done),
    .code     (sar_code)
  );

  // --------------------------------------------------------------
  // result store and read protection
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      res_q   <= '0;
      ladj_q  <= 1'b0;
      block_q <= 1'b0;
    end else if (clk_en) begin
      if (sar_done && !block_q) begin
        res_q <= sar_code;
      end
      ladj_q <= mux_q[MUX_LADJ_BIT];
      if (reg_rd && reg_addr == OFF_RES_LOW) begin
        block_q <= 1'b1;
      end else if (reg_rd && reg_addr == OFF_RES_HIGH) begin
        block_q <= 1'b0;
      end
    end
  end

  // read data, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= RST_BYTE;
    end else if (clk_en) begin
      rdata_q <= RST_BYTE;
      if (reg_rd) begin
        unique case (reg_addr)
          OFF_RES_LOW:  rdata_q <= low_byte(res_q, mux_q[MUX_LADJ_BIT]);
          OFF_RES_HIGH: rdata_q <= high_byte(res_q, mux_q[MUX_LADJ_BIT]);
          OFF_CSR_A:    rdata_q <= csra_q;
          OFF_CSR_B:    rdata_q <= csrb_q;
          OFF_MUX_SEL:  rdata_q <= mux_q;
          OFF_PWR_SAVE: rdata_q <= pwr_q;
          default:      rdata_q <= RST_BYTE;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_q;

  // --------------------------------------------------------------
  // analog routing
  // --------------------------------------------------------------
  // routing decode from latched choice
  always_comb begin
    analog_on   = conv_en;
    ref_sel     = ref_act_q;
    ref_to_pin  = conv_en && ref_act_q != REF_PIN;
    pos_input   = {1'b0, ch_act_q[5], ch_act_q[2:0]};  // pin number 0..15
    neg_is_gnd  = 1'b1;
    neg_input   = 4'h0;
    amp_bypass  = 1'b1;
    amp_gain    = GAIN_1X;
    sel_bandgap = 1'b0;
    if (ch_act_q[4:0] < 5'h08) begin
      pos_input = {1'b0, ch_act_q[5], ch_act_q[2:0]};
    end else if (ch_act_q[4:0] < 5'h10) begin
      // gain pairs 0/1 and 2/3 of each group
      amp_bypass = 1'b0;
      neg_is_gnd = 1'b0;
      pos_input  = {1'b0, ch_act_q[5], 1'b0, ch_act_q[1], 1'b0};
      neg_input  = {ch_act_q[5], 1'b0, ch_act_q[1], 1'b1};
      amp_gain   = ch_act_q[2] ? GAIN_200X : (ch_act_q[0] ? GAIN_10X : GAIN_1X);
    end else if (ch_act_q[4:0] < 5'h18) begin
      // eight inputs against common negative of the group, no gain
      amp_bypass = 1'b0;
      neg_is_gnd = 1'b0;
      pos_input  = {1'b0, ch_act_q[5], ch_act_q[2:0]};
      neg_input  = {ch_act_q[5], 3'h1};
    end else if (ch_act_q[4:0] == 5'h1e) begin
      sel_bandgap = 1'b1;
    end else if (ch_act_q[4:0] == 5'h1f) begin
      pos_input = 5'h00;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  power_gate_a: assert property (!powered |=> !sar_busy)
    else $error("converter busy while powered off");
  enable_gate_a: assert property (clk_en && !conv_en |=> !csra_q[CSRA_START_BIT])
    else $error("start held while disabled");
  start_clear_a: assert property (clk_en && sar_done |=> !csra_q[CSRA_START_BIT])
    else $error("start bit not cleared at completion");
  done_set_a: assert property (clk_en && sar_done |=> csra_q[CSRA_DONE_BIT])
    else $error("done flag not set");
  result_store_a: assert property (clk_en && sar_done && !block_q |=> res_q == $past(sar_code))
    else $error("result not stored");
  result_block_a: assert property (block_q && clk_en |=> $stable(res_q))
    else $error("result changed while blocked");
  block_lift_a: assert property (clk_en && reg_rd && reg_addr == OFF_RES_HIGH |=> !block_q)
    else $error("block not lifted");
  channel_hold_a: assert property (state_q == acr_convert |=> $stable(ch_act_q))
    else $error("channel changed mid conversion");
  left_read_a: assert property (clk_en && reg_rd && reg_addr == OFF_RES_HIGH && ladj_q
    && mux_q[MUX_LADJ_BIT] |=> reg_rdata == $past(res_q[9:2]))
    else $error("left justified high byte wrong");

  conv_done_c: cover property (sar_done);
  discard_c: cover property (sar_done && block_q);
  first_conv_c: cover property (sar_go && first_q);

endmodule

//--- core/acr_pkg.sv
/*
  acr_pkg: constants, register offsets and field layout of the converter
  control and result block.
  assumes: single 25 MHz clock, plain register port with 8-bit data.
*/
package acr_pkg;

  // --------------------------------------------------------------
  // register port geometry
  // --------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RES_W  = 10;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_RES_LOW  = 4'h0;  // result_low_byte
  localparam logic [ADDR_W-1:0] OFF_RES_HIGH = 4'h1;  // result_high_byte
  localparam logic [ADDR_W-1:0] OFF_CSR_A    = 4'h2;  // control_status_a_register
  localparam logic [ADDR_W-1:0] OFF_CSR_B    = 4'h3;  // control_status_b_register
  localparam logic [ADDR_W-1:0] OFF_MUX_SEL  = 4'h4;  // multiplexer_select_register
  localparam logic [ADDR_W-1:0] OFF_PWR_SAVE = 4'h5;  // power_saving_register_zero

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int CSRA_EN_BIT    = 7;  // converter_enable_bit
  localparam int CSRA_START_BIT = 6;  // start_conversion_bit
  localparam int CSRA_DONE_BIT  = 4;  // conversion_done_flag
  localparam int CSRB_CH5_BIT   = 3;  // channel select bit 5
  localparam int MUX_REF_HI     = 7;  // reference_select_bits
  localparam int MUX_REF_LO     = 6;
  localparam int MUX_LADJ_BIT   = 5;  // left_adjust_bit
  localparam int MUX_CH_HI      = 4;  // channel select bits 4:0
  localparam int PWR_OFF_BIT    = 0;  // converter_power_off_bit

  // --------------------------------------------------------------
  // reset values and masks
  // --------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_BYTE     = 8'h00;
  localparam logic [DATA_W-1:0] CSRB_WR_MASK = 8'h08;
  localparam logic [DATA_W-1:0] PWR_RST      = 8'h01;  // converter starts powered off

  // --------------------------------------------------------------
  // reference and gain codes
  // --------------------------------------------------------------
  localparam logic [1:0] REF_PIN    = 2'h0;  // reference_pin
  localparam logic [1:0] REF_SUPPLY = 2'h1;  // analog_supply_pin
  localparam logic [1:0] REF_1V1    = 2'h2;
  localparam logic [1:0] REF_2V56   = 2'h3;
  localparam logic [1:0] GAIN_1X    = 2'h0;
  localparam logic [1:0] GAIN_10X   = 2'h1;
  localparam logic [1:0] GAIN_200X  = 2'h2;

  // --------------------------------------------------------------
  // timing in converter clock cycles
  // --------------------------------------------------------------
  localparam int CLK_MHZ       = 25;
  localparam int CONV_CLK_KHZ  = 200;
  localparam int CONV_DIV      = (CLK_MHZ * 1000) / CONV_CLK_KHZ;
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES  = 25;
  localparam int CNT_W         = 5;

  // conversion sequencer states
  typedef enum logic [1:0] {acr_idle, acr_wait_edge, acr_convert} acr_state_t;

endpackage

//--- core/acr_sar.sv
/*
  acr_sar: successive approximation sequencer; counts converter clock
  ticks, takes the comparator level each bit step and returns the code.
  assumes: comparator level is already synchronised to core_clk.
*/
`timescale 1ns/1ns
module acr_sar
  import acr_pkg::*;
(
  // clock and control
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             tick,
  input  wire logic             go,
  input  wire logic             first,
  // comparator side
  input  wire logic             cmp_high,
  output logic      [RES_W-1:0] trial,
  // result side
  output logic                  busy,
  output logic                  done,
  output logic      [RES_W-1:0] code
);

  logic [CNT_W-1:0] cnt_q;   // remaining converter cycles
  logic [RES_W-1:0] sar_q;   // approximation register
  logic [RES_W-1:0] bit_q;   // current trial bit
  logic             busy_q;
  logic             done_q;

  assign trial = sar_q | bit_q;
  assign busy  = busy_q;
  assign done  = done_q;
  assign code  = sar_q;

  // sequence: load length, then one bit decision per tick near the end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q  <= '0;
      sar_q  <= '0;
      bit_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (go && !busy_q) begin
        cnt_q  <= first ? CNT_W'(FIRST_CYCLES) : CNT_W'(NORMAL_CYCLES);
        sar_q  <= '0;
        bit_q  <= '0;
        busy_q <= 1'b1;
      end else if (busy_q && tick) begin
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == CNT_W'(RES_W + 1)) begin
          bit_q <= {1'b1, {(RES_W-1){1'b0}}};
        end else if (bit_q != '0) begin
          // keep the trial bit only when input stays above
          if (cmp_high) begin
            sar_q <= sar_q | bit_q;
          end
          bit_q <= bit_q >> 1;
        end
        if (cnt_q == CNT_W'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

endmodule

//--- dv/acr_analog_model.sv
/*
  acr_analog_model: far-side model of the analog inputs and comparator.
  assumes: bench drives one level code per selected input; no analog noise.
*/
`timescale 1ns/1ns
module acr_analog_model
  import acr_pkg::*;
(
  // clock and converter state
  input  wire logic             core_clk,
  input  wire logic             analog_on,
  // trial code and routing
  input  wire logic [RES_W-1:0] dac_code,
  input  wire logic [4:0]       pos_input,
  input  wire logic [RES_W-1:0] level [32],
  // comparator answer
  output logic                  cmp_level
);
  // --------------------------------------------------------------
  // comparator
  // --------------------------------------------------------------
  logic toggle_q;  // junk pattern while the converter is unpowered

  initial toggle_q = 1'b0;

  // a dead comparator gives no steady level, so changing junk is driven
  always @(posedge core_clk) begin
    toggle_q <= ~toggle_q;
  end

  // ground-referenced compare
  // input sits half a step above its code, so the search lands on it
  assign cmp_level = analog_on ? (dac_code <= level[pos_input]) : toggle_q;
endmodule

//--- dv/analog_converter_control_result_test.sv
/*
  analog_converter_control_result_test: self-checking bench of acr_top.
  assumes: analog model on the far side, 25 MHz clock, clk_en held high.
*/
`timescale 1ns/1ns
module analog_converter_control_result_test;
  import acr_pkg::*;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic              core_clk;
  logic              reset;
  logic              clk_en;   // freezing the block would skew timing
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              cmp_level;
  logic [RES_W-1:0]  dac_code;
  logic              analog_on;
  logic [1:0]        ref_sel;
  logic              ref_to_pin;
  logic [4:0]        pos_input;
  logic              neg_is_gnd;
  logic [3:0]        neg_input;
  logic              amp_bypass;
  logic [1:0]        amp_gain;
  logic              sel_bandgap;
  logic [RES_W-1:0]  level [32];  // code each input presents
  typedef struct {logic [7:0] exp; logic [7:0] mask;} acr_note_t;
  acr_note_t         notes [$];   // expected read data, oldest first
  acr_note_t         cur;
  logic              rd_pend;
  int                errors;
  int                num_checks;
  int                cyc_cnt;
  logic [7:0]        d;
  logic [RES_W-1:0]  t1;
  logic [RES_W-1:0]  t2;
  int                cyc;
  logic [4:0]        ch_list [8];  // channel codes walked by the decode test

  acr_top u_acr_top (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmp_level(cmp_level), .dac_code(dac_code),
    .analog_on(analog_on), .ref_sel(ref_sel), .ref_to_pin(ref_to_pin),
    .pos_input(pos_input), .neg_is_gnd(neg_is_gnd), .neg_input(neg_input),
    .amp_bypass(amp_bypass), .amp_gain(amp_gain), .sel_bandgap(sel_bandgap));

  acr_analog_model u_acr_analog_model (.core_clk(core_clk), .analog_on(analog_on),
    .dac_code(dac_code), .pos_input(pos_input), .level(level), .cmp_level(cmp_level));

  // --------------------------------------------------------------
  // clock, compare, verdict
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [RES_W-1:0] exp, input logic [RES_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // read data stands one cycle only, so it is taken at the next edge
  always @(posedge core_clk) begin
    if (rd_pend) begin
      cur = notes.pop_front();
      if (cur.mask != 8'h00) chk("reg_rdata", 10'(cur.exp & cur.mask), 10'(reg_rdata & cur.mask));
    end
    rd_pend <= reg_rd;
  end

  // hang guard; all tests need well under this many cycles
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      errors++;
      complete_run();
    end
  end

  // --------------------------------------------------------------
  // register port tasks: one-cycle strobes, one idle edge after each
  // --------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m,
                    output logic [7:0] v);
    notes.push_back('{e, m});
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
  endtask

  // start one conversion and count cycles until the start bit drops
  task automatic conv(input logic [RES_W-1:0] t, output int n);
    for (int i = 0; i < 32; i++) level[i] = t;
    wr(OFF_CSR_A, 8'h90);  // clear the done flag first
    wr(OFF_CSR_A, 8'hc0);
    n = 2;
    rd(OFF_CSR_A, 8'h40, 8'h40, d);
    d = 8'h40;
    while (d[CSRA_START_BIT] !== 1'b0 && n < 6000) begin
      rd(OFF_CSR_A, 8'h00, 8'h00, d);
      n += 2;
    end
    rd(OFF_CSR_A, 8'h10, 8'h50, d);
  endtask

  // read both result bytes, low first, and check the placement chosen by ladj
  task automatic res(input logic [RES_W-1:0] t, input logic ladj);
    if (ladj) begin
      rd(OFF_RES_LOW, {t[1:0], 6'h00}, 8'hff, d);
      rd(OFF_RES_HIGH, t[9:2], 8'hff, d);
    end else begin
      rd(OFF_RES_LOW, t[7:0], 8'hff, d);
      rd(OFF_RES_HIGH, {6'h00, t[9:8]}, 8'hff, d);
    end
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_pend = 1'b0;
    for (int i = 0; i < 32; i++) level[i] = '0;
    ch_list = '{5'd0, 5'd7, 5'd8, 5'd15, 5'd16, 5'd23, 5'd30, 5'd31};
    void'($urandom(94));
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    // reset values and an unmapped offset
    rd(OFF_PWR_SAVE, PWR_RST, 8'hff, d);
    rd(OFF_RES_HIGH, 8'h00, 8'hff, d);
    rd(4'hf, 8'h00, 8'hff, d);
    // selections written while disabled stay out of effect
    wr(OFF_MUX_SEL, 8'hc0);
    chk("ref_sel", 10'(0), 10'(ref_sel));
    // start refused while powered off
    wr(OFF_CSR_A, 8'hc0);
    rd(OFF_CSR_A, 8'h00, 8'h40, d);
    chk("analog_on", 10'(0), 10'(analog_on));
    wr(OFF_CSR_A, 8'h00);
    wr(OFF_PWR_SAVE, 8'h00);
    wr(OFF_CSR_A, 8'h80);
    chk("analog_on", 10'(1), 10'(analog_on));
    // every reference code, all but the pin code routed to the pin
    for (int r = 0; r < 4; r++) begin
      wr(OFF_MUX_SEL, {2'(r), 6'h00});
      repeat (4) @(posedge core_clk);
      chk("ref_sel", 10'(r), 10'(ref_sel));
      chk("ref_to_pin", 10'(r != 0), 10'(ref_to_pin));
    end
    // channel decode: single, gain pair, common negative, bandgap, ground
    foreach (ch_list[k]) begin
      t2 = 10'(ch_list[k]);
      wr(OFF_MUX_SEL, 8'(t2));
      repeat (4) @(posedge core_clk);
      chk("amp_bypass", 10'(t2 < 8 || t2 > 23), 10'(amp_bypass));
      chk("neg_is_gnd", 10'(t2 < 8 || t2 > 23), 10'(neg_is_gnd));
      chk("amp_gain", 10'(t2 == 15 ? GAIN_200X : GAIN_1X), 10'(amp_gain));
      chk("neg_input", 10'(t2 == 15 ? 3 : (t2 >= 8 && t2 <= 23)), 10'(neg_input));
      chk("sel_bandgap", 10'(t2 == 30), 10'(sel_bandgap));
    end
    // channel bit 5 lives in the second control register
    wr(OFF_CSR_B, 8'h08);
    wr(OFF_MUX_SEL, 8'h03);
    repeat (4) @(posedge core_clk);
    chk("pos_input", 10'(5'h0b), 10'(pos_input));
    wr(OFF_CSR_B, 8'h00);
    wr(OFF_MUX_SEL, 8'h02);
    // first conversion is the long one
    t1 = 10'($urandom_range(0, 1023));
    conv(t1, cyc);
    chk("first_len", 10'(1), 10'(cyc >= 25 * 125 - 4 && cyc <= 26 * 125 + 12));
    res(t1, 1'b0);
    wr(OFF_MUX_SEL, 8'h22);
    res(t1, 1'b1);
    wr(OFF_MUX_SEL, 8'h02);
    // low read blocks; the next result is lost but still flags done
    rd(OFF_RES_LOW, t1[7:0], 8'hff, d);
    t2 = t1 ^ 10'h3ff;
    conv(t2, cyc);
    chk("normal_len", 10'(1), 10'(cyc >= 13 * 125 - 4 && cyc <= 14 * 125 + 12));
    rd(OFF_RES_HIGH, {6'h00, t1[9:8]}, 8'hff, d);
    res(t1, 1'b0);
    // block lifted, so a fresh conversion lands in both bytes
    t2 = 10'($urandom_range(0, 1023));
    conv(t2, cyc);
    res(t2, 1'b0);
    // channel change in mid-conversion waits for completion
    wr(OFF_CSR_A, 8'hc0);
    repeat (200) @(posedge core_clk);  // past the first converter tick
    wr(OFF_MUX_SEL, 8'h05);
    repeat (2) @(posedge core_clk);
    chk("pos_input", 10'(2), 10'(pos_input));
    repeat (2500) @(posedge core_clk);
    chk("pos_input", 10'(5), 10'(pos_input));
    // software switches the converter off before sleeping
    wr(OFF_CSR_A, 8'h00);
    chk("analog_on", 10'(0), 10'(analog_on));
    complete_run();
  end
endmodule
